/* File: logic/kwd_detector.sv */
// Key wake-up detector: registers, detection, request and pull-up control
`timescale 1ns/1ps

module kwd_detector (
  input  wire logic                      clock,
  input  wire logic                      nrst,
  input  wire logic [kwd_pkg::KWD_KEYS-1:0] key_in,
  input  wire logic                      low_speed_clock,
  input  wire logic [kwd_pkg::KWD_AW-1:0] addr,
  input  wire logic [kwd_pkg::KWD_DW-1:0] wdata,
  input  wire logic                      wr,
  input  wire logic                      rd,
  output logic      [kwd_pkg::KWD_DW-1:0] rdata,
  output logic                           key_request,
  output logic                           intr_request,
  output logic                           irq,
  output logic      [kwd_pkg::KWD_KEYS-1:0] pullup_on
);
  import kwd_pkg::*;

  // Overview of the data flow through this block:
  // Key pins and the low-speed clock pin enter through one synchroniser bank,
  // so every key level and every low-speed tick share the same latency.
  // Each key compares its filtered level against its own active condition.
  // Hits of enabled keys are merged into one sticky request register.
  // The request stays set until a clear write with no new hit beside it.
  // A hit in the clearing cycle wins, so no detection is ever lost.
  // The pull-up drive is shared: one global enable, gated per key by use.
  // In pulsed mode a small timer opens a window at the start of each
  // interval, and keys are only judged at the last cycle of that window.
  // Outside the window the pins may float, so levels are held, not watched.
  //
  // Hazards that the structure below avoids:
  // A floating pin toggles quickly; the agreement filter holds its last level
  // instead of passing noise, which keeps the edge reference stable.
  // The edge reference follows every cycle in static mode, but only at the
  // sampling instants in pulsed mode, so an edge between samples still counts.
  // Level conditions are ignored in pulsed mode: a level seen only while the
  // pull-up is off would be meaningless.
  // With the low-speed clock stopped no tick arrives, the timer never
  // reaches its sampling instant, and no key is detected in pulsed mode.
  // Users must start that clock before selecting pulsed mode.

  // Configuration state
  logic [KWD_KEYS-1:0]   use_en;          // Per-key use enable
  logic [1:0]            cond [KWD_KEYS]; // Per-key active condition
  logic [7:0]            pu_ctrl;         // Pull-up control register
  logic [KWD_EV_W-1:0]   status;          // Sticky events
  logic [KWD_EV_W-1:0]   mask;            // Event mask
  logic                  req;             // Merged key request
  logic [KWD_KEYS-1:0]   prev;            // Last compared key levels
  logic [KWD_KEYS-1:0]   next_use_en;
  logic [1:0]            next_cond [KWD_KEYS];
  logic [7:0]            next_pu_ctrl;
  logic [KWD_EV_W-1:0]   next_status;
  logic [KWD_EV_W-1:0]   next_mask;
  logic                  next_req;
  logic [KWD_KEYS-1:0]   next_prev;
  logic [KWD_DW-1:0]     next_rdata;
  logic [KWD_KEYS-1:0]   next_pullup_on;
  logic                  fs_prev;         // Last filtered low-speed clock
  logic                  next_fs_prev;

  // Synchronised pins
  logic [KWD_SYNC_BITS-1:0] sync_lvl;     // Keys in low bits, clock on top
  logic [KWD_KEYS-1:0]      key_lvl;      // Filtered key levels
  logic                     fs_lvl;       // Filtered low-speed clock

  // Decode helpers
  logic                  pe;              // Global pull-up enable
  logic                  pulsed_pullup_select;             // Pulsed pull-up select
  logic                  set_hit;         // Address in key setting range
  logic [3:0]            set_idx;         // Key index of a setting access
  logic [KWD_KEYS-1:0]   hit;             // Per-key detection this cycle
  logic                  any_hit;         // Merged detection
  logic                  clr_req;         // Valid clear write

  kwd_timer_if tif ();

  // Pins cross into the clock domain.
  // The low-speed clock rides on the top lane of the same bank, so a tick
  // and the key levels it gates are always aligned in time.
  // Latency from pin to filtered level is a few system cycles; the user
  // sees this as a short delay between a key change and the request.
  // The bank is reset with the block, so all lanes start low; a key held
  // high at reset is therefore seen high only after the stages fill.
  // Pins at their pulled-up idle level show one rising step after reset;
  // it cannot raise the request since every use enable is clear by then.
  kwd_sync #(
    .W (KWD_SYNC_BITS)
  ) u_sync (
    .clock    (clock),
    .nrst     (nrst),
    .async_in ({low_speed_clock, key_in}),
    .level    (sync_lvl)
  );

  kwd_pulse_timer u_timer (
    .clock (clock),
    .nrst  (nrst),
    .tif   (tif.timer)
  );

  assign key_lvl          = sync_lvl[KWD_KEYS-1:0];
  assign fs_lvl           = sync_lvl[KWD_KEYS];
  assign pe               = pu_ctrl[KWD_PE_BIT];
  assign pulsed_pullup_select              = pu_ctrl[KWD_DPE_BIT];
  assign set_hit          = (addr >= KWD_SET_FIRST) && (addr <= KWD_SET_LAST);
  assign set_idx          = 4'(addr - KWD_SET_FIRST);
  // Timer runs on low-speed clock edges; with that clock stopped nothing is sampled
  assign tif.fs_tick      = fs_lvl && !fs_prev;
  assign tif.run          = pe && pulsed_pullup_select;
  assign tif.width_sel    = pu_ctrl[KWD_T1_LSB +: 2];
  assign tif.interval_sel = pu_ctrl[KWD_T2_LSB +: 2];
  assign clr_req          = wr && (addr == KWD_CLR) && (wdata[3:0] == KWD_CLR_CODE);

  // Per-key detection against the selected condition.
  // One lane per key, each a pure function of its filtered level, its edge
  // reference, its condition, the pulsed-mode run flag and the timer's sampling instant.
  // The use enable gates only the result, so a key that is turned on later
  // already has a valid edge reference and cannot see a false edge.
  // Conditions outside the four codes cannot occur; the static default branch only
  // keeps the logic free of latches, while the pulsed one also rejects the level codes.
  // Each lane is cheap: two compares and a small multiplexer.
  genvar k;
  generate
    for (k = 0; k < KWD_KEYS; k++) begin : g_key
      logic det;                          // Condition met for this key
      always_comb begin
        det = 1'b0;
        if (tif.run) begin
          // Edges between successive window samples; levels unsupported
          if (tif.sample) begin
            case (kwd_cond_e'(cond[k]))
              KWD_FALL: det = prev[k] && !key_lvl[k];
              KWD_RISE: det = !prev[k] && key_lvl[k];
              default:  det = 1'b0;
            endcase
          end
        end else begin
          // Continuous watch in static or no pull-up mode
          case (kwd_cond_e'(cond[k]))
            KWD_LOW:  det = !key_lvl[k];
            KWD_HIGH: det = key_lvl[k];
            KWD_FALL: det = prev[k] && !key_lvl[k];
            KWD_RISE: det = !prev[k] && key_lvl[k];
            default:  det = 1'b0;
          endcase
        end
      end
      assign hit[k] = det && use_en[k];
    end
  endgenerate

  assign any_hit = |hit;

  // Next values of configuration, request, events and read data.
  // Writes and reads decode one address map, the clear place write-only and the request status read-only; unmapped places are
  // ignored on write and read back as zero.
  // The clear write compares the low nibble only, so upper bits are free.
  // Event bits are sticky; a one written to a status bit clears it, but an
  // event in the same cycle sets it again, because a lost event is worse
  // than a repeated one.
  // Read data are built here and registered, so they stand one cycle only.
  always_comb begin
    next_use_en  = use_en;
    next_cond    = cond;
    next_pu_ctrl = pu_ctrl;
    next_mask    = mask;
    next_status  = status;
    next_req     = req;
    next_rdata   = '0;
    next_fs_prev = fs_lvl;
    next_prev    = prev;
    // Edge reference follows every cycle, or only at samples when pulsed
    if (!tif.run || tif.sample) begin
      next_prev = key_lvl;
    end
    // Register writes
    if (wr) begin
      if (set_hit) begin
        next_use_en[set_idx] = wdata[KWD_EN_BIT];
        next_cond[set_idx]   = wdata[KWD_COND_LSB +: 2];
      end else if (addr == KWD_PU_CTRL) begin
        next_pu_ctrl = wdata & KWD_PU_WMASK;
      end else if (addr == KWD_STATUS) begin
        next_status = status & ~wdata[KWD_EV_W-1:0]; // Write one to clear
      end else if (addr == KWD_MASK) begin
        next_mask = wdata[KWD_EV_W-1:0];
      end
    end
    // Clear drops all pending detections at once
    if (clr_req) begin
      next_req = 1'b0;
    end
    // A detection in the clearing cycle still raises the request
    if (any_hit) begin
      next_req = 1'b1;
    end
    // Events set after any clear so the set wins
    if (any_hit && !req) begin
      next_status[KWD_EV_KEY] = 1'b1;
    end
    if (tif.pulse_start) begin
      next_status[KWD_EV_PULSE] = 1'b1;
    end
    // Register reads, answered the next cycle
    if (rd) begin
      if (set_hit) begin
        next_rdata[KWD_EN_BIT]         = use_en[set_idx];
        next_rdata[KWD_COND_LSB +: 2]  = cond[set_idx];
      end else if (addr == KWD_PU_CTRL) begin
        next_rdata = pu_ctrl;
      end else if (addr == KWD_STATUS) begin
        next_rdata[KWD_EV_W-1:0] = status;
      end else if (addr == KWD_MASK) begin
        next_rdata[KWD_EV_W-1:0] = mask;
      end else if (addr == KWD_REQ_STAT) begin
        next_rdata[0] = req;
        next_rdata[1] = tif.pulse_on;
      end
    end
  end

  // Shared pull-up drive, gated per key by its use enable
  always_comb begin
    for (int i = 0; i < KWD_KEYS; i++) begin
      next_pullup_on[i] = pe && use_en[i] && (!pulsed_pullup_select || tif.pulse_on);
    end
  end

  // Register all state.
  // Synchronous reset returns every configuration field to its documented
  // value: conditions to falling edge, enables and pull-ups off.
  // Pull-ups off at reset keep the pins from drawing current until
  // software has chosen which keys are in use.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      use_en    <= '0;
      for (int i = 0; i < KWD_KEYS; i++) begin
        cond[i] <= KWD_COND_RST;
      end
      pu_ctrl   <= KWD_PU_RST;
      status    <= KWD_EV_RST;
      mask      <= KWD_EV_RST;
      req       <= 1'b0;
      prev      <= '0;
      fs_prev   <= 1'b0;
      rdata     <= '0;
      pullup_on <= '0;
    end else begin
      use_en    <= next_use_en;
      cond      <= next_cond;
      pu_ctrl   <= next_pu_ctrl;
      status    <= next_status;
      mask      <= next_mask;
      req       <= next_req;
      prev      <= next_prev;
      fs_prev   <= next_fs_prev;
      rdata     <= next_rdata;
      pullup_on <= next_pullup_on;
    end
  end

  // Active-high request to standby logic and interrupt controller
  assign key_request  = req;
  assign intr_request = req;
  assign irq          = |(status & mask);
endmodule // kwd_detector

/* File: logic/kwd_pkg.sv */
// Constants shared by the key wake-up detector modules
package kwd_pkg;
  localparam int unsigned KWD_KEYS      = 14;             // Number of key inputs
  localparam int unsigned KWD_SYNC_BITS = KWD_KEYS + 1;   // Keys plus low-speed clock
  localparam int unsigned KWD_AW        = 32;             // Register address width
  localparam int unsigned KWD_DW        = 8;              // Register data width

  // Register offsets, as printed (byte addresses on the plain port)
  localparam logic [31:0] KWD_SET_FIRST = 32'hfffff360;   // Key setting register, key 0
  localparam logic [31:0] KWD_SET_LAST  = 32'hfffff36d;   // Key setting register, key 13
  localparam logic [31:0] KWD_PU_CTRL   = 32'hfffff371;   // Pull-up control register
  localparam logic [31:0] KWD_CLR       = 32'hfffff372;   // Key request clear register
  localparam logic [31:0] KWD_STATUS    = 32'hfffff374;   // Sticky event status
  localparam logic [31:0] KWD_MASK      = 32'hfffff375;   // Event mask
  localparam logic [31:0] KWD_REQ_STAT  = 32'hfffff376;   // Live request and pull-up window state

  // Key setting register fields
  localparam int unsigned KWD_EN_BIT    = 0;              // Use enable
  localparam int unsigned KWD_COND_LSB  = 4;              // Active condition, bits 5:4
  localparam logic [1:0]  KWD_COND_RST  = 2'h2;           // Condition after reset
  localparam logic        KWD_EN_RST    = 1'h0;           // Use enable after reset

  // Pull-up control register fields
  localparam int unsigned KWD_PE_BIT    = 0;              // Global pull-up enable
  localparam int unsigned KWD_DPE_BIT   = 1;              // Pulsed pull-up select
  localparam int unsigned KWD_T1_LSB    = 2;              // Pulse width select, bits 3:2
  localparam int unsigned KWD_T2_LSB    = 4;              // Pulse interval select, bits 5:4
  localparam logic [7:0]  KWD_PU_RST    = 8'h00;          // Pull-up control after reset
  localparam logic [7:0]  KWD_PU_WMASK  = 8'h3f;          // Bit 7 and 6 kept at zero

  // Clear code and status layout
  localparam logic [3:0]  KWD_CLR_CODE  = 4'ha;           // Pattern that clears requests
  localparam int unsigned KWD_EV_KEY    = 0;              // Key request raised
  localparam int unsigned KWD_EV_PULSE  = 1;              // Pull-up pulse started
  localparam int unsigned KWD_EV_W      = 2;              // Number of event bits
  localparam logic [1:0]  KWD_EV_RST    = 2'h0;           // Status and mask after reset

  // Dynamic pull-up timing, in low-speed clock cycles
  localparam logic [9:0]  KWD_T1_BASE   = 10'h004;        // Shortest pulse width, 4 cycles
  localparam logic [10:0] KWD_T2_BASE   = 11'h080;        // Shortest interval, 128 cycles
  localparam logic [9:0]  KWD_CNT_RST   = 10'h000;        // Interval counter after reset

  // Condition encodings
  typedef enum logic [1:0] {
    KWD_LOW  = 2'b00,
    KWD_HIGH = 2'b01,
    KWD_FALL = 2'b10,
    KWD_RISE = 2'b11
  } kwd_cond_e;
endpackage

/* File: logic/kwd_timer_if.sv */
// Signals between the key detector core and its pull-up pulse timer
`timescale 1ns/1ps
interface kwd_timer_if;
  logic       fs_tick;     // One cycle per low-speed clock rising edge
  logic       run;         // Pulsed mode active
  logic [1:0] width_sel;   // Pulse width select
  logic [1:0] interval_sel;// Pulse interval select
  logic       pulse_on;    // Pull-up window open
  logic       pulse_start; // First cycle of a window
  logic       sample;      // Sampling instant inside the window

  modport core  (output fs_tick, run, width_sel, interval_sel,
                 input pulse_on, pulse_start, sample);
  modport timer (input fs_tick, run, width_sel, interval_sel,
                 output pulse_on, pulse_start, sample);
endinterface // kwd_timer_if

/* File: logic/kwd_sync.sv */
// Three-stage input synchroniser with agreement filter, one lane per bit
`timescale 1ns/1ps
module kwd_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level
);
  import kwd_pkg::*;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_lane
      logic s1, s2, s3, lvl;      // Stages and filtered level
      logic next_lvl;             // Filtered level to come
      // Level moves only once stages two and three agree
      always_comb begin
        next_lvl = lvl;
        if (s2 == s3) begin
          next_lvl = s3;
        end
      end
      always_ff @(posedge clock) begin
        if (!nrst) begin
          s1  <= 1'b0;
          s2  <= 1'b0;
          s3  <= 1'b0;
          lvl <= 1'b0;
        end else begin
          s1  <= async_in[g];
          s2  <= s1;
          s3  <= s2;
          lvl <= next_lvl;
        end
      end
      assign level[g] = lvl;
    end
  endgenerate
endmodule // kwd_sync

/* File: logic/kwd_pulse_timer.sv */
// Interval counter in low-speed clock cycles for pulsed pull-ups
`timescale 1ns/1ps
module kwd_pulse_timer (
  input wire logic clock,
  input wire logic nrst,
  kwd_timer_if.timer tif
);
  import kwd_pkg::*;

  logic [9:0] cnt;         // Low-speed cycles since window start
  logic [9:0] next_cnt;
  logic       next_start;
  logic       next_sample;
  logic [9:0] width;       // Pulse width in low-speed cycles
  logic [9:0] last;        // Final count of an interval

  // Counter restarts each interval; window is its first cycles
  always_comb begin
    width       = KWD_T1_BASE << tif.width_sel;
    last        = 10'((KWD_T2_BASE << tif.interval_sel) - 11'h001);
    next_cnt    = cnt;
    next_start  = 1'b0;
    next_sample = 1'b0;
    if (!tif.run) begin
      next_cnt = KWD_CNT_RST;                  // Idle: hold at window start
    end else if (tif.fs_tick) begin
      next_cnt    = (cnt == last) ? KWD_CNT_RST : cnt + 10'h001;
      next_start  = (cnt == last);
      next_sample = (next_cnt == width - 10'h001); // Last cycle of the window
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      cnt             <= KWD_CNT_RST;
      tif.pulse_start <= 1'b0;
      tif.sample      <= 1'b0;
    end else begin
      cnt             <= next_cnt;
      tif.pulse_start <= next_start;
      tif.sample      <= next_sample;
    end
  end

  // Window open during the first width cycles of each interval
  assign tif.pulse_on = tif.run && (cnt < width);
endmodule // kwd_pulse_timer

/* File: tb/kwd_key_switches.sv */
// Key switch model: a pressed key pulls low, an open key follows its pull-up or floats
`timescale 1ns/1ps
module kwd_key_switches (
  input  wire logic                         clock,
  input  wire logic [kwd_pkg::KWD_KEYS-1:0] pressed,
  input  wire logic [kwd_pkg::KWD_KEYS-1:0] pullup_on,
  output logic      [kwd_pkg::KWD_KEYS-1:0] key_in
);
  import kwd_pkg::*;
  logic [KWD_KEYS-1:0] drift; // Undriven pin level, flips every cycle
  // Floating pins never hold a steady value
  initial drift = '0;
  always @(posedge clock) drift <= ~drift;
  // Pressed wins, then pull-up, else float
  always_comb begin
    for (int k = 0; k < KWD_KEYS; k++) begin
      key_in[k] = pressed[k] ? 1'b0 : (pullup_on[k] ? 1'b1 : drift[k]);
    end
  end
endmodule // kwd_key_switches

/* File: tb/kwd_detector_checker.sv */
// Port-level assertions for the key wake-up detector
`timescale 1ns/1ps
module kwd_detector_checker (
  input wire logic                         clock,
  input wire logic                         nrst,
  input wire logic [kwd_pkg::KWD_KEYS-1:0] key_in,
  input wire logic                         low_speed_clock,
  input wire logic [kwd_pkg::KWD_AW-1:0]   addr,
  input wire logic [kwd_pkg::KWD_DW-1:0]   wdata,
  input wire logic                         wr,
  input wire logic                         rd,
  input wire logic [kwd_pkg::KWD_DW-1:0]   rdata,
  input wire logic                         key_request,
  input wire logic                         intr_request,
  input wire logic                         irq,
  input wire logic [kwd_pkg::KWD_KEYS-1:0] pullup_on
);
  import kwd_pkg::*;
  logic [KWD_KEYS-1:0] en_s;  // Shadow of the use enables
  logic [5:0]          pu_s;  // Shadow of the pull-up control
  logic                clr_w; // Clear code written this cycle
  assign clr_w = wr && addr == KWD_CLR && wdata[3:0] == KWD_CLR_CODE;
  // Follow register writes as the design takes them
  always_ff @(posedge clock) begin
    if (!nrst) begin
      en_s <= '0;
      pu_s <= '0;
    end else if (wr) begin
      if (addr == KWD_PU_CTRL) pu_s <= wdata[5:0];
      if (addr >= KWD_SET_FIRST && addr <= KWD_SET_LAST) en_s[addr[3:0]] <= wdata[0];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  AST_INTR_SAME: assert property (intr_request == key_request)
    else $error("intr request differs");
  AST_PU_OFF: assert property (!$past(pu_s[0]) |-> pullup_on == '0)
    else $error("pull-up on while disabled");
  AST_PU_STATIC: assert property ($past(pu_s[1:0]) == 2'h1 |-> pullup_on == $past(en_s))
    else $error("static pull-up wrong");
  AST_PU_UNUSED: assert property ((pullup_on & ~$past(en_s)) == '0)
    else $error("pull-up on unused key");
  AST_PU_SHARED: assert property (pullup_on != '0 |-> pullup_on == $past(en_s))
    else $error("pull-ups not shared");
  AST_REQ_CLEAR: assert property ($fell(key_request) |-> $past(clr_w))
    else $error("request fell without clear");
  AST_REQ_ENABLED: assert property ($rose(key_request) |-> $past(en_s) != '0)
    else $error("request with no key enabled");
  AST_PU_READ: assert property (rd && addr == KWD_PU_CTRL |=> rdata == {2'h0, $past(pu_s)})
    else $error("pull-up control read wrong");
endmodule // kwd_detector_checker

/* File: tb/tb_kwd_detector.sv */
// Testbench for the key wake-up detector
`timescale 1ns/1ps
module tb_kwd_detector;
  import kwd_pkg::*;
  logic                clock, nrst, low_speed_clock, wr, rd, key_request, intr_request, irq;
  logic [KWD_AW-1:0]   addr;
  logic [KWD_DW-1:0]   wdata, rdata, v;
  logic [KWD_KEYS-1:0] key_in, pullup_on, pressed;
  int                  mismatches, comparisons, cycles, n, hi, lo;

  kwd_detector kwd_detector_i (.clock(clock), .nrst(nrst), .key_in(key_in),
    .low_speed_clock(low_speed_clock), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .key_request(key_request), .intr_request(intr_request), .irq(irq),
    .pullup_on(pullup_on));
  kwd_key_switches kwd_key_switches_i (.clock(clock), .pressed(pressed),
    .pullup_on(pullup_on), .key_in(key_in));

  // System clock and low-speed clock of eight cycles, running from the start
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    low_speed_clock = 1'b0;
    #3;
    forever #40 low_speed_clock = ~low_speed_clock;
  end
  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_n(input int c);
    repeat (c) @(posedge clock);
  endtask
  task automatic wreg(input logic [31:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rreg(input logic [31:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Cycles that key 3's pull-up holds one level
  task automatic span(input logic lvl, output int len);
    len = 0;
    while (pullup_on[3] === lvl && len < 10000) begin
      wait_n(1);
      #1 len++;
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    {nrst, wr, rd, addr, wdata, pressed} = '0;
    wait_n(3);
    nrst <= 1'b1;
    wait_n(4);
    // Reset values, unwritable bits, unmapped place
    rreg(KWD_SET_FIRST, v); check("set0", v, 8'h20);
    rreg(32'hfffff370, v); check("unmapped", v, 8'h00);
    wreg(KWD_PU_CTRL, 8'hff); rreg(KWD_PU_CTRL, v); check("pu", v, 8'h3f);
    // Static setup of keys 0 and 3 on falling edge
    wreg(KWD_PU_CTRL, 8'h01);
    wreg(KWD_SET_FIRST + 3, 8'h21);
    wreg(KWD_SET_FIRST, 8'h21);
    wait_n(8);
    check("pullups", pullup_on, 16'h0009);
    wreg(KWD_CLR, 8'h0a);
    wreg(KWD_MASK, 8'h01);
    wreg(KWD_STATUS, 8'h03);
    // Every condition code on key 3, idle then active
    for (int c = 0; c < 4; c++) begin
      pressed[3] <= c[0];
      wait_n(8);
      wreg(KWD_SET_FIRST + 3, {2'h0, c[1:0], 4'h1});
      wait_n(8);
      wreg(KWD_CLR, 8'h0a);
      wait_n(2);
      check("idle", key_request, 1'b0);
      pressed[3] <= ~c[0];
      wait_n(8);
      check("detect", key_request, 1'b1);
      check("intr", intr_request, 1'b1);
      pressed[3] <= c[0];
      wait_n(8);
      wreg(KWD_CLR, 8'h0a);
      wait_n(2);
      check("cleared", key_request, 1'b0);
    end
    // Two keys before one clear, interrupt mask and status
    wreg(KWD_SET_FIRST + 3, 8'h21);
    pressed[3] <= 1'b0;
    wait_n(8);
    wreg(KWD_CLR, 8'h0a);
    wreg(KWD_STATUS, 8'h01);
    pressed[3] <= 1'b1;
    wait_n(8);
    pressed[0] <= 1'b1;
    wait_n(8);
    rreg(KWD_STATUS, v); check("status", v, 8'h01);
    wreg(KWD_MASK, 8'h00); check("masked", irq, 1'b0);
    wreg(KWD_MASK, 8'h01); check("unmasked", irq, 1'b1);
    wreg(KWD_CLR, 8'h0a);
    wreg(KWD_STATUS, 8'h01);
    wait_n(8);
    check("both gone", key_request, 1'b0);
    check("irq off", irq, 1'b0);
    pressed[0] <= 1'b0;
    wait_n(8);
    pressed[0] <= 1'b1;
    wait_n(8);
    check("again", key_request, 1'b1);
    pressed <= '0;
    // Pulsed pull-ups: width and interval for every select
    for (int s = 0; s < 4; s++) begin
      wreg(KWD_PU_CTRL, {2'h0, s[1:0], s[1:0], 2'h3});
      span(1'b1, n);
      span(1'b0, n);
      span(1'b1, hi);
      span(1'b0, lo);
      check("width", hi, (4 << s) * 8);
      check("interval", hi + lo, (128 << s) * 8);
    end
    // Edge seen in pulsed mode within one interval
    wreg(KWD_PU_CTRL, 8'h03);
    wait_n(1100);
    wreg(KWD_CLR, 8'h0a);
    check("dyn idle", key_request, 1'b0);
    pressed[3] <= 1'b1;
    n = 0;
    while (key_request !== 1'b1 && n < 1200) begin
      wait_n(1);
      #1 n++;
    end
    check("dyn detect", n <= 1040, 1'b1);
    rreg(KWD_STATUS, v); check("pulse event", v[1], 1'b1);
    rreg(KWD_REQ_STAT, v); check("live request", v[0], 1'b1);
    tally_and_finish();
  end
endmodule // tb_kwd_detector

bind kwd_detector kwd_detector_checker kwd_detector_checker_i (.clock(clock), .nrst(nrst),
  .key_in(key_in), .low_speed_clock(low_speed_clock), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .key_request(key_request), .intr_request(intr_request),
  .irq(irq), .pullup_on(pullup_on));
